// File: inc/anar_pkg.sv
package anar_pkg;
    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_STAT = 6'h01;
    localparam logic [5:0] IDX_ADV = 6'h04;
    localparam logic [5:0] IDX_LPA = 6'h05;
    localparam logic [5:0] IDX_OVR = 6'h10;
    localparam logic [5:0] IDX_XSTAT = 6'h11;
    // ==========================================================
    // Control, override and status register fields
    localparam int CTRL_SPEED = 13;
    localparam int CTRL_AN_EN = 12;
    localparam int CTRL_RESTART = 9;
    localparam int CTRL_DUPLEX = 8;
    localparam int OVR_BIT = 15;
    localparam int STAT_AN_DONE = 5;
    localparam int XSTAT_AN_DONE = 4;
    // ==========================================================
    // Advertisement and partner field positions
    localparam int F_NP = 15;
    localparam int F_ACK = 14;
    localparam int F_RF = 13;
    localparam int F_T4 = 9;
    // Fixed status word: all abilities except 100Base-T4, negotiation able
    localparam logic [15:0] STAT_CAPS = 16'h7808;
    // Mask of partner bits taken from the received word
    localparam logic [15:0] LPA_MASK = 16'he1ff & ~16'h0200;
    // ==========================================================
    // Reset values
    localparam logic [3:0] TECH_ALL = 4'hf;
    localparam logic [3:0] TECH_NONE = 4'h0;
    localparam logic [4:0] SEL_8023 = 5'h01;
    localparam logic [2:0] RSVD_RST = 3'h0;
    localparam logic [15:0] LPA_RST = 16'h0000;
endpackage

// File: src/anar_regs.sv
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module anar_regs
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Straps
    input wire logic hardware_software_select_pin,
    input wire logic an_enable_pin,
    // Negotiation sublayer
    input wire logic [15:0] lcw_rx_data,
    input wire logic lcw_rx_valid,
    input wire logic an_complete,
    output logic [15:0] lcw_tx_data,
    output logic an_enable,
    output logic an_restart,
    output logic an_idle,
    output logic speed_100,
    output logic full_duplex
);
    import anar_pkg::*;

    // ==========================================================
    // Bus phase tracking
    logic dp_wr_r, dp_rd_r, rd_done_r;
    logic [5:0] dp_idx_r;
    logic [31:0] hrdata_r;
    wire logic addr_ok = hsel && htrans[1] && hready;

    // Register state
    logic strap_done_r;
    logic an_en_r, speed_r, duplex_r, restart_r, ovr_r;
    logic adv_np_r, adv_rf_r;
    logic [2:0] adv_rsvd_r;
    logic [3:0] tech_r;
    logic [4:0] sel_r;
    logic [15:0] lpa_r;

    // Write strobes, decoded in the data phase
    wire logic wr_ctrl = dp_wr_r && (dp_idx_r == IDX_CTRL);
    wire logic wr_adv = dp_wr_r && (dp_idx_r == IDX_ADV);
    wire logic wr_ovr = dp_wr_r && (dp_idx_r == IDX_OVR);
    wire logic wr_cw = wr_adv && ovr_r;

    // Read-side words
    wire logic [15:0] ctrl_word = {2'b00, speed_r, an_en_r, 3'b000,
        duplex_r, 8'h00};
    wire logic [15:0] stat_word = STAT_CAPS
        | (16'(an_complete) << STAT_AN_DONE);
    wire logic [15:0] adv_word = {adv_np_r, 1'b0, adv_rf_r, 3'b000,
        1'b0, tech_r, sel_r};
    wire logic [15:0] ovr_word = {ovr_r, 15'h0000};
    wire logic [15:0] xstat_word = 16'(an_complete) << XSTAT_AN_DONE;

    // Read mux; unmapped addresses read zero
    function automatic logic [15:0] rd_mux(input logic [5:0] idx,
        input logic [15:0] c, input logic [15:0] s,
        input logic [15:0] a, input logic [15:0] l,
        input logic [15:0] o, input logic [15:0] x);
        logic [15:0] v;
        v = 16'h0000;
        if (idx == IDX_CTRL)
            v = c;
        else if (idx == IDX_STAT)
            v = s;
        else if (idx == IDX_ADV)
            v = a;
        else if (idx == IDX_LPA)
            v = l;
        else if (idx == IDX_OVR)
            v = o;
        else if (idx == IDX_XSTAT)
            v = x;
        return v;
    endfunction

    wire logic [15:0] rd_word = rd_mux(dp_idx_r, ctrl_word, stat_word,
        adv_word, lpa_r, ovr_word, xstat_word);

    // Reads wait one cycle so a write just ahead is already visible
    assign hreadyout = !(dp_rd_r && !rd_done_r);
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // ==========================================================
    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_r <= 1'b0;
            dp_rd_r <= 1'b0;
            dp_idx_r <= 6'h00;
        end
        else if (hreadyout)
        begin
            dp_wr_r <= addr_ok && hwrite;
            dp_rd_r <= addr_ok && !hwrite;
            dp_idx_r <= haddr[7:2];
        end
    end

    // Read data is loaded in the wait cycle of a read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_done_r <= 1'b0;
            hrdata_r <= 32'h0000_0000;
        end
        else
        begin
            rd_done_r <= dp_rd_r && !rd_done_r;
            if (dp_rd_r && !rd_done_r)
                hrdata_r <= {16'h0000, rd_word};
        end
    end

    // ==========================================================
    // Straps are caught on the first edge after reset release
    wire logic an_en_strap = hardware_software_select_pin ?
        an_enable_pin : 1'b1;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            strap_done_r <= 1'b0;
        else
            strap_done_r <= 1'b1;
    end

    // Control and override registers; restart self-clears
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            an_en_r <= 1'b1;
            speed_r <= 1'b1;
            duplex_r <= 1'b0;
            restart_r <= 1'b0;
            ovr_r <= 1'b0;
        end
        else
        begin
            restart_r <= wr_ctrl && hwdata[CTRL_RESTART];
            if (!strap_done_r)
                an_en_r <= an_en_strap;
            else if (wr_ctrl)
            begin
                an_en_r <= hwdata[CTRL_AN_EN];
                speed_r <= hwdata[CTRL_SPEED];
                duplex_r <= hwdata[CTRL_DUPLEX];
            end
            if (wr_ovr)
                ovr_r <= hwdata[OVR_BIT];
        end
    end

    // ==========================================================
    // Advertisement register; override-write fields need ovr_r
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            adv_np_r <= 1'b0;
            adv_rf_r <= 1'b0;
            adv_rsvd_r <= RSVD_RST;
            tech_r <= TECH_ALL;
            sel_r <= SEL_8023;
        end
        else
        begin
            if (!strap_done_r)
                tech_r <= an_en_strap ? TECH_ALL : TECH_NONE;
            else if (wr_cw)
                tech_r <= hwdata[8:5];
            if (wr_cw)
            begin
                adv_rsvd_r <= hwdata[12:10];
                sel_r <= hwdata[4:0];
            end
            if (wr_adv)
            begin
                adv_np_r <= hwdata[F_NP];
                adv_rf_r <= hwdata[F_RF];
            end
        end
    end

    // Transmitted code word; reserved stored bits stay local
    assign lcw_tx_data = {adv_np_r, 1'b0, adv_rf_r, 3'b000, 1'b0,
        tech_r, sel_r};
    assign an_enable = an_en_r;
    assign an_idle = !an_en_r;
    assign an_restart = restart_r;
    assign speed_100 = speed_r;
    assign full_duplex = duplex_r;

    // ==========================================================
    // Partner ability; cleared on restart, loaded per received word
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            lpa_r <= LPA_RST;
        else if (restart_r || !an_en_r)
            lpa_r <= LPA_RST;
        else if (lcw_rx_valid)
            lpa_r <= lcw_rx_data & LPA_MASK;
    end

    // ==========================================================
    // Checks
    a_rsvd_read_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (dp_rd_r && rd_done_r && dp_idx_r == IDX_ADV)
        |-> hrdata[12:9] == 4'h0)
        else $error("reserved advertisement bits read non-zero");

    a_cw_locked: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_adv && !ovr_r && strap_done_r)
        |=> ($stable(tech_r) && $stable(sel_r) && $stable(adv_rsvd_r)))
        else $error("override-write bits changed while locked");

    a_cw_taken: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_adv && ovr_r && strap_done_r)
        |=> tech_r == $past(hwdata[8:5]))
        else $error("override write not taken");

    a_t4_never: assert property (
        @(posedge hclk) disable iff (!hresetn)
        lcw_tx_data[F_T4] == 1'b0 && adv_word[F_T4] == 1'b0)
        else $error("100Base-T4 advertised");

    // The sent word must carry what software wrote, not merely mirror the flops
    a_tx_fields: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_cw && strap_done_r) |=> lcw_tx_data[8:0] == $past(hwdata[8:0]))
        else $error("code word differs from advertisement");

    a_idle_mode: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_ctrl && !hwdata[CTRL_AN_EN] && strap_done_r)
        |=> (an_idle && !an_enable && speed_100 == $past(hwdata[13])))
        else $error("negotiation off did not select idle mode");

    a_tech_default: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(strap_done_r) |-> tech_r == ((hardware_software_select_pin && !an_enable_pin) ?
            TECH_NONE : TECH_ALL))
        else $error("ability defaults do not follow straps");

    a_status_caps: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (dp_rd_r && rd_done_r && dp_idx_r == IDX_STAT)
        |-> hrdata[15:11] == STAT_CAPS[15:11])
        else $error("status capabilities changed");

    a_lpa_capture: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (lcw_rx_valid && !restart_r && an_en_r)
        |=> lpa_r == ($past(lcw_rx_data) & LPA_MASK))
        else $error("partner word not captured");

    a_lpa_rsvd: assert property (
        @(posedge hclk) disable iff (!hresetn)
        lpa_r[12:9] == 4'h0)
        else $error("partner reserved or T4 bit set");

    a_lpa_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        restart_r |=> lpa_r == LPA_RST ##1 (lpa_r == LPA_RST || $past(lcw_rx_valid)))
        else $error("partner register not cleared on restart");

    a_read_wait: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (addr_ok && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    // Writes never stall the bus
    a_write_nowait: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (addr_ok && hwrite) |=> hreadyout)
        else $error("write inserted a wait state");

    // A held restart would keep wiping the partner word
    a_restart_pulse: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_ctrl && hwdata[CTRL_RESTART]) |=> an_restart ##1 !an_restart)
        else $error("restart is not a single pulse");

    // Software writes must not disturb the partner word
    a_lpa_locked: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (dp_wr_r && dp_idx_r == IDX_LPA && !lcw_rx_valid && !restart_r && an_en_r)
        |=> $stable(lpa_r))
        else $error("partner register changed by a write");
endmodule
`default_nettype wire

// File: testbench/anar_link_partner.sv
`timescale 1ns/1ns
`default_nettype none
module anar_link_partner
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench command
    input wire logic send_req,
    input wire logic [15:0] send_word,
    // Code word towards the device
    output logic [15:0] lcw_rx_data,
    output logic lcw_rx_valid
);
    // ==========================================================
    // Remote partner: one-cycle word, then the data lines keep toggling
    // Toggling idle data keeps a sloppy capture from passing by luck
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lcw_rx_valid <= 1'b0;
            lcw_rx_data <= 16'h5a5a;
        end
        else
        begin
            lcw_rx_valid <= send_req;
            lcw_rx_data <= send_req ? send_word : ~lcw_rx_data;
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import anar_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hw_sel = 1'b0;
    logic an_pin = 1'b1;
    logic an_done = 1'b0;
    logic send_req = 1'b0;
    logic [15:0] send_word = 16'h0;
    wire logic hready;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic [15:0] rx_data;
    wire logic rx_valid;
    wire logic [15:0] lcw_tx_data;
    wire logic an_idle;
    wire logic an_enable;
    wire logic an_restart;
    wire logic speed_100;
    wire logic full_duplex;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int restarts = 0;
    // 10 MHz clock
    always #50 hclk = ~hclk;
    // Restart pulses seen, one per commanded restart
    always @(posedge hclk)
    begin
        if (an_restart === 1'b1)
            restarts++;
    end
    anar_regs u_anar_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .hardware_software_select_pin(hw_sel), .an_enable_pin(an_pin),
        .lcw_rx_data(rx_data), .lcw_rx_valid(rx_valid), .an_complete(an_done),
        .lcw_tx_data(lcw_tx_data), .an_enable(an_enable), .an_restart(an_restart),
        .an_idle(an_idle), .speed_100(speed_100), .full_duplex(full_duplex));
    anar_link_partner u_anar_link_partner (.hclk(hclk), .hresetn(hresetn),
        .send_req(send_req), .send_word(send_word), .lcw_rx_data(rx_data),
        .lcw_rx_valid(rx_valid));
    // ==========================================================
    // Verdict, comparison and bus tasks
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // A hang costs a mismatch rather than an endless run
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Single word transfer; the master waits on hready, never a fixed count
    task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, i, 2'b00};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [5:0] i, input logic [15:0] d);
        logic [31:0] r;
        bus(1'b1, i, {16'h0, d}, r);
    endtask
    task automatic rd(input logic [5:0] i, input logic [15:0] e);
        logic [31:0] r;
        bus(1'b0, i, 32'h0, r);
        chk(r, {16'h0, e});
    endtask
    // Partner word: request edge, valid edge, capture edge
    task automatic send(input logic [15:0] w);
        send_word <= w;
        send_req <= 1'b1;
        @(posedge hclk);
        send_req <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    task automatic do_reset(input logic sel, input logic pin);
        hresetn <= 1'b0;
        hw_sel <= sel;
        an_pin <= pin;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask
    // ==========================================================
    // Test sequence
    initial
    begin
        do_reset(1'b0, 1'b1);
        rd(IDX_ADV, 16'h01e1);
        rd(IDX_LPA, LPA_RST);
        rd(IDX_STAT, STAT_CAPS);
        rd(6'h02, 16'h0000);
        chk({31'h0, hresp}, 32'h0);
        $display("test reset_values done");
        wr(IDX_ADV, 16'h0001);
        rd(IDX_ADV, 16'h01e1);
        $display("test override_off done");
        wr(IDX_OVR, 16'h8000);
        wr(IDX_ADV, 16'h03e1);
        rd(IDX_ADV, 16'h01e1);
        wr(IDX_ADV, 16'ha021);
        rd(IDX_ADV, 16'ha021);
        chk({16'h0, lcw_tx_data}, 32'h0000a021);
        wr(IDX_OVR, 16'h0000);
        wr(IDX_ADV, 16'h01e1);
        rd(IDX_ADV, 16'h0021);
        wr(IDX_OVR, 16'h8000);
        wr(IDX_ADV, 16'h01e1);
        wr(IDX_OVR, 16'h0000);
        $display("test override_on done");
        an_done <= 1'b1;
        send(16'hffff);
        rd(IDX_LPA, 16'he1ff);
        wr(IDX_LPA, 16'h0000);
        rd(IDX_LPA, 16'he1ff);
        send(16'h4021);
        rd(IDX_LPA, 16'h4021);
        rd(IDX_STAT, 16'h7828);
        rd(IDX_XSTAT, 16'h0010);
        wr(IDX_CTRL, 16'h3200);
        an_done <= 1'b0;
        rd(IDX_LPA, 16'h0000);
        chk(restarts, 32'h1);
        $display("test partner_word done");
        wr(IDX_CTRL, 16'h0100);
        rd(IDX_CTRL, 16'h0100);
        chk({28'h0, an_enable, an_idle, speed_100, full_duplex}, 32'h5);
        send(16'hffff);
        rd(IDX_LPA, 16'h0000);
        wr(6'h02, 16'hffff);
        rd(6'h02, 16'h0000);
        $display("test negotiation_off done");
        do_reset(1'b1, 1'b0);
        rd(IDX_ADV, 16'h0001);
        chk({31'h0, an_idle}, 32'h1);
        $display("test hardware_mode done");
        wrap_up();
    end
endmodule
`default_nettype wire
